// [design/freq_ref_pkg.sv]
// constants and state layout for the frequency reference combiner
package freq_ref_pkg;

  // ----------------------------------------------------------------
  // register byte offsets (one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MAIN_SOURCE_SELECT = 8'h00;
  localparam logic [7:0] OFS_MAIN_GAIN          = 8'h04;
  localparam logic [7:0] OFS_AUX_SOURCE_SELECT  = 8'h08;
  localparam logic [7:0] OFS_COMBINE_SELECT     = 8'h0c;
  localparam logic [7:0] OFS_AUX_RANGE_BASIS    = 8'h10;
  localparam logic [7:0] OFS_AUX_RANGE_PERCENT  = 8'h14;
  localparam logic [7:0] OFS_COMBINE_OFFSET     = 8'h18;
  localparam logic [7:0] OFS_PRESET_FREQUENCY   = 8'h1c;
  localparam logic [7:0] OFS_MAXIMUM_FREQUENCY  = 8'h20;
  localparam logic [7:0] OFS_STATUS_FREQ_A      = 8'h24;
  localparam logic [7:0] OFS_STATUS_FREQ_B      = 8'h28;
  localparam logic [7:0] OFS_STATUS_TARGET      = 8'h2c;
  localparam logic [7:0] OFS_STATUS_DIG_A       = 8'h30;
  localparam logic [7:0] OFS_STATUS_DIG_B       = 8'h34;

  // ----------------------------------------------------------------
  // reset values and limits (frequency in 0.01 Hz, gain in 0.001)
  // ----------------------------------------------------------------
  localparam logic [3:0]  RST_MAIN_SEL   = 4'h0;
  localparam logic [13:0] RST_GAIN       = 14'h03e8;  // 1.000
  localparam logic [13:0] MAX_GAIN       = 14'h2710;  // 10.000
  localparam logic [3:0]  RST_AUX_SEL    = 4'h0;
  localparam logic [7:0]  RST_COMBINE    = 8'h00;
  localparam logic [1:0]  RST_BASIS      = 2'h0;
  localparam logic [7:0]  RST_RANGE_PCT  = 8'h64;     // 100 %
  localparam logic [7:0]  MAX_RANGE_PCT  = 8'h96;     // 150 %
  localparam logic [15:0] RST_OFFSET     = 16'h0000;
  localparam logic [15:0] RST_PRESET     = 16'h1388;  // 50.00 Hz
  localparam logic [15:0] RST_MAXF       = 16'h1388;  // 50.00 Hz
  localparam logic [15:0] MIN_MAXF       = 16'h1388;  // 50.00 Hz
  localparam logic [15:0] TOP_MAXF       = 16'hea60;  // 600.00 Hz

  // ----------------------------------------------------------------
  // scaling units
  // ----------------------------------------------------------------
  localparam int PCT_FULL   = 10000;  // source percent, 0.01 % per lsb
  localparam int GAIN_UNITY = 1000;
  localparam int RANGE_FULL = 100;

  // ----------------------------------------------------------------
  // source codes and combine codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_DIG_VOLATILE = 4'h0;
  localparam logic [3:0] SRC_DIG_RETAINED = 4'h1;
  localparam logic [3:0] SRC_ANALOG_ONE   = 4'h2;
  localparam logic [3:0] SRC_PULSE        = 4'h5;
  localparam logic [3:0] SRC_MULTI_REF    = 4'h6;
  localparam logic [3:0] SRC_SIMPLE_PLC   = 4'h7;
  localparam logic [3:0] SRC_PID          = 4'h8;
  localparam logic [3:0] SRC_COMM         = 4'h9;
  localparam logic [3:0] SRC_KEYPAD_POT   = 4'ha;
  localparam logic [3:0] UNIT_A           = 4'h0;
  localparam logic [3:0] UNIT_ARITH       = 4'h1;
  localparam logic [3:0] UNIT_A_OR_B      = 4'h2;
  localparam logic [3:0] UNIT_A_OR_ARITH  = 4'h3;
  localparam logic [3:0] UNIT_B_OR_ARITH  = 4'h4;
  localparam logic [3:0] TENS_SUM         = 4'h0;
  localparam logic [3:0] TENS_DIFF        = 4'h1;
  localparam logic [3:0] TENS_MAX         = 4'h2;
  localparam logic [3:0] TENS_MIN         = 4'h3;
  localparam logic [1:0] BASIS_MAIN       = 2'h2;

  // ----------------------------------------------------------------
  // whole state of the combiner
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]         main_sel;
    logic [13:0]        gain;
    logic [3:0]         aux_sel;
    logic [7:0]         combine;
    logic [1:0]         basis;
    logic [7:0]         range_pct;
    logic [15:0]        offset;
    logic [15:0]        preset;
    logic [15:0]        maxf;
    logic signed [23:0] dig_a;
    logic signed [23:0] dig_b;
    logic signed [23:0] freq_a;
    logic signed [23:0] freq_b;
    logic signed [23:0] target;
    logic [31:0]        rdata;
  } comb_state_t;

endpackage

// [design/frequency_reference_combiner.sv]
// frequency reference combiner: main/aux selection, scaling and combining
//
// Summary of operation
// - effective A is the selected main source times the main gain
// - units digit 0: target is A alone
// - units digit 1: target is the arithmetic result
// - units digit 2: A while switch inactive, B while active
// - units digit 3: A while switch inactive, arithmetic result while active
// - units digit 4: B while switch inactive, arithmetic result while active
// - tens digit 0: result is A plus B
// - tens digit 1: result is A minus B
// - tens digit 2: result is whichever has larger magnitude
// - tens digit 3: result is whichever has smaller magnitude
// - offset added only when the arithmetic result is used
// - aux span relative to maximum frequency (1) or to A (2)
// - aux full scale in superposition equals range percent of the basis, default 100 %
// - digital aux in superposition ignores preset, moves only by up/down
// - digital sources start from the preset frequency
// - codes 8, 9, 10 take PID, communication, keypad potentiometer
// - aux selection uses the same source codes as main
// - percent sources scale so 100 % equals maximum frequency, except aux in superposition
// - code 0 reloads preset at power-up, code 1 reloads retained value
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module frequency_reference_combiner
  import freq_ref_pkg::*;
#(
  parameter int FW         = 24,
  parameter int UPDN_STEP  = 1
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_b,
  // register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  // reference sources, signed percent in 0.01 % steps
  input  wire logic signed [15:0] analog_input_one,
  input  wire logic signed [15:0] pulse_input,
  input  wire logic signed [15:0] multi_ref_input,
  input  wire logic signed [15:0] simple_plc_input,
  input  wire logic signed [15:0] pid_input,
  input  wire logic signed [15:0] comm_input,
  input  wire logic signed [15:0] keypad_pot_input,
  // switch terminal and digital adjustment
  input  wire logic               source_switch,
  input  wire logic               up_pulse,
  input  wire logic               down_pulse,
  input  wire logic               power_up_load,
  input  wire logic signed [FW-1:0] retained_a,
  input  wire logic signed [FW-1:0] retained_b,
  // results in 0.01 Hz
  output logic signed [FW-1:0]    freq_a,
  output logic signed [FW-1:0]    freq_b,
  output logic signed [FW-1:0]    target_frequency,
  output logic signed [FW-1:0]    digital_ref_a,
  output logic signed [FW-1:0]    digital_ref_b
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // percent of a base, 10000 meaning full base
  function automatic logic signed [47:0] pct_of(input logic signed [47:0] pct,
                                                 input logic signed [47:0] base);
    pct_of = (pct * base) / 48'(PCT_FULL);
  endfunction

  function automatic logic signed [47:0] abs48(input logic signed [47:0] v);
    abs48 = (v < 0) ? -v : v;
  endfunction

  // saturate to the datapath width so a large gain never wraps the sign
  function automatic logic signed [23:0] sat(input logic signed [47:0] v);
    if (v > 48'sd8388607) begin
      sat = 24'sh7fffff;
    end else if (v < -48'sd8388607) begin
      sat = -24'sh7fffff;
    end else begin
      sat = v[23:0];
    end
  endfunction

  // clamp a written word into [0, hi]
  function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] hi);
    clamp16 = (v > {16'h0000, hi}) ? hi : v[15:0];
  endfunction

  // value of one source channel; shared by main and aux selection
  function automatic logic signed [47:0] src_pick(input logic [3:0] sel,
                                                   input logic signed [47:0] dig,
                                                   input logic signed [47:0] base);
    logic signed [47:0] pct;
    pct = 48'sd0;
    case (sel)
      SRC_ANALOG_ONE: pct = 48'(analog_input_one);
      SRC_PULSE:      pct = 48'(pulse_input);
      SRC_MULTI_REF:  pct = 48'(multi_ref_input);
      SRC_SIMPLE_PLC: pct = 48'(simple_plc_input);
      SRC_PID:        pct = 48'(pid_input);
      SRC_COMM:       pct = 48'(comm_input);
      SRC_KEYPAD_POT: pct = 48'(keypad_pot_input);
      default:        pct = 48'sd0;                 // reserved codes give zero
    endcase
    if (sel == SRC_DIG_VOLATILE || sel == SRC_DIG_RETAINED) begin
      src_pick = dig;
    end else begin
      src_pick = pct_of(pct, base);
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  comb_state_t st_ff;
  comb_state_t nxt_st;

  logic [3:0]         units;
  logic [3:0]         tens;
  logic               superpose;

  logic signed [47:0] maxf_w;
  logic signed [47:0] a_raw;
  logic signed [47:0] a_val;
  logic signed [47:0] b_base;
  logic signed [47:0] b_span;
  logic signed [47:0] b_val;
  logic signed [47:0] arith;
  logic signed [47:0] arith_off;
  logic signed [47:0] tgt;

  logic signed [23:0] dig_a_step;
  logic signed [23:0] dig_b_step;

  // ----------------------------------------------------------------
  // datapath, rebuilt every cycle so a switch change lands next edge
  // ----------------------------------------------------------------
  always_comb begin
    units     = st_ff.combine[3:0];
    tens      = st_ff.combine[7:4];
    superpose = (units == UNIT_ARITH) || (units == UNIT_A_OR_ARITH) ||
                (units == UNIT_B_OR_ARITH);
    maxf_w    = 48'(st_ff.maxf);
    a_raw     = src_pick(st_ff.main_sel, 48'(st_ff.dig_a), maxf_w);
    a_val     = (a_raw * $signed(48'(st_ff.gain))) / 48'(GAIN_UNITY);
    // span of B follows A when A is the basis
    b_base    = (st_ff.basis == BASIS_MAIN) ? abs48(a_val) : maxf_w;
    b_span    = (b_base * $signed(48'(st_ff.range_pct))) / 48'(RANGE_FULL);
    b_val     = src_pick(st_ff.aux_sel, 48'(st_ff.dig_b),
                         superpose ? b_span : maxf_w);

    case (tens)
      TENS_SUM:  arith = a_val + b_val;
      TENS_DIFF: arith = a_val - b_val;
      TENS_MAX:  arith = (abs48(a_val) >= abs48(b_val)) ? a_val : b_val;
      TENS_MIN:  arith = (abs48(a_val) <= abs48(b_val)) ? a_val : b_val;
      default:   arith = a_val + b_val;
    endcase
    arith_off = arith + 48'(st_ff.offset);

    case (units)
      UNIT_A:          tgt = a_val;
      UNIT_ARITH:      tgt = arith_off;
      UNIT_A_OR_B:     tgt = source_switch ? b_val : a_val;
      UNIT_A_OR_ARITH: tgt = source_switch ? arith_off : a_val;
      UNIT_B_OR_ARITH: tgt = source_switch ? arith_off : b_val;
      default:         tgt = a_val;
    endcase
  end

  // ----------------------------------------------------------------
  // digital references: up/down within [0, maximum frequency]
  // ----------------------------------------------------------------
  always_comb begin
    dig_a_step = st_ff.dig_a;
    dig_b_step = st_ff.dig_b;
    if (up_pulse && !down_pulse) begin
      dig_a_step = st_ff.dig_a + 24'(UPDN_STEP);
      dig_b_step = st_ff.dig_b + 24'(UPDN_STEP);
    end else if (down_pulse && !up_pulse) begin
      dig_a_step = st_ff.dig_a - 24'(UPDN_STEP);
      dig_b_step = st_ff.dig_b - 24'(UPDN_STEP);
    end

    if (dig_a_step < 0) dig_a_step = 24'sh000000;
    if (dig_b_step < 0) dig_b_step = 24'sh000000;
    if (dig_a_step > 24'(st_ff.maxf)) dig_a_step = 24'(st_ff.maxf);
    if (dig_b_step > 24'(st_ff.maxf)) dig_b_step = 24'(st_ff.maxf);
  end

  // ----------------------------------------------------------------
  // next state: settings writes, digital loads, results, read data
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // settings; out-of-range numeric writes are clamped rather than refused, select fields keep their low bits
    if (reg_wr) begin
      case (reg_addr)
        OFS_MAIN_SOURCE_SELECT: nxt_st.main_sel = reg_wdata[3:0];
        OFS_MAIN_GAIN:          nxt_st.gain = 14'(clamp16(reg_wdata, 16'(MAX_GAIN)));
        OFS_AUX_SOURCE_SELECT:  nxt_st.aux_sel = reg_wdata[3:0];
        OFS_COMBINE_SELECT:     nxt_st.combine = reg_wdata[7:0];
        OFS_AUX_RANGE_BASIS:    nxt_st.basis = reg_wdata[1:0];
        OFS_AUX_RANGE_PERCENT:  nxt_st.range_pct = 8'(clamp16(reg_wdata, 16'(MAX_RANGE_PCT)));
        OFS_COMBINE_OFFSET:     nxt_st.offset = clamp16(reg_wdata, st_ff.maxf);
        OFS_PRESET_FREQUENCY:   nxt_st.preset = clamp16(reg_wdata, st_ff.maxf);
        OFS_MAXIMUM_FREQUENCY: begin
          nxt_st.maxf = clamp16(reg_wdata, TOP_MAXF);
          if (reg_wdata < 32'(MIN_MAXF)) nxt_st.maxf = MIN_MAXF;
        end
        default: ;
      endcase
    end

    // digital references; a load pulse outranks a key step
    nxt_st.dig_a = dig_a_step;
    nxt_st.dig_b = dig_b_step;
    if (power_up_load) begin
      nxt_st.dig_a = (st_ff.main_sel == SRC_DIG_RETAINED) ? retained_a
                                                          : 24'(st_ff.preset);
      if (superpose) begin
        nxt_st.dig_b = 24'sh000000;
      end else begin
        nxt_st.dig_b = (st_ff.aux_sel == SRC_DIG_RETAINED) ? retained_b
                                                           : 24'(st_ff.preset);
      end
    end

    // results registered so every output comes from a flop
    nxt_st.freq_a = sat(a_val);
    nxt_st.freq_b = sat(b_val);
    nxt_st.target = sat(tgt);

    // read data stands only in the cycle after the strobe
    nxt_st.rdata = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        OFS_MAIN_SOURCE_SELECT: nxt_st.rdata = 32'(st_ff.main_sel);
        OFS_MAIN_GAIN:          nxt_st.rdata = 32'(st_ff.gain);
        OFS_AUX_SOURCE_SELECT:  nxt_st.rdata = 32'(st_ff.aux_sel);
        OFS_COMBINE_SELECT:     nxt_st.rdata = 32'(st_ff.combine);
        OFS_AUX_RANGE_BASIS:    nxt_st.rdata = 32'(st_ff.basis);
        OFS_AUX_RANGE_PERCENT:  nxt_st.rdata = 32'(st_ff.range_pct);
        OFS_COMBINE_OFFSET:     nxt_st.rdata = 32'(st_ff.offset);
        OFS_PRESET_FREQUENCY:   nxt_st.rdata = 32'(st_ff.preset);
        OFS_MAXIMUM_FREQUENCY:  nxt_st.rdata = 32'(st_ff.maxf);
        OFS_STATUS_FREQ_A:      nxt_st.rdata = 32'(st_ff.freq_a);
        OFS_STATUS_FREQ_B:      nxt_st.rdata = 32'(st_ff.freq_b);
        OFS_STATUS_TARGET:      nxt_st.rdata = 32'(st_ff.target);
        OFS_STATUS_DIG_A:       nxt_st.rdata = 32'(st_ff.dig_a);
        OFS_STATUS_DIG_B:       nxt_st.rdata = 32'(st_ff.dig_b);
        default:                nxt_st.rdata = 32'h00000000;  // unmapped reads zero
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_ff.main_sel  <= RST_MAIN_SEL;
      st_ff.gain      <= RST_GAIN;
      st_ff.aux_sel   <= RST_AUX_SEL;
      st_ff.combine   <= RST_COMBINE;
      st_ff.basis     <= RST_BASIS;
      st_ff.range_pct <= RST_RANGE_PCT;
      st_ff.offset    <= RST_OFFSET;
      st_ff.preset    <= RST_PRESET;
      st_ff.maxf      <= RST_MAXF;
      st_ff.dig_a     <= 24'(RST_PRESET);
      st_ff.dig_b     <= 24'(RST_PRESET);
      st_ff.freq_a    <= 24'sh000000;
      st_ff.freq_b    <= 24'sh000000;
      st_ff.target    <= 24'sh000000;
      st_ff.rdata     <= 32'h00000000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from the state register
  // ----------------------------------------------------------------
  assign reg_rdata        = st_ff.rdata;
  assign freq_a           = st_ff.freq_a;
  assign freq_b           = st_ff.freq_b;
  assign target_frequency = st_ff.target;
  assign digital_ref_a    = st_ff.dig_a;
  assign digital_ref_b    = st_ff.dig_b;

endmodule // frequency_reference_combiner

`default_nettype wire

// [tb/freq_ref_combiner_chk.sv]
// assertion checker for the frequency reference combiner
`timescale 1ns/1ns
`default_nettype none

module freq_ref_combiner_chk
  import freq_ref_pkg::*;
#(
  parameter int FW = 24
) (
  // clock and reset
  input wire logic                 core_clk,
  input wire logic                 rst_b,
  // register write side
  input wire logic [7:0]           reg_addr,
  input wire logic [31:0]          reg_wdata,
  input wire logic                 reg_wr,
  // switch terminal and results
  input wire logic                 source_switch,
  input wire logic signed [FW-1:0] freq_a,
  input wire logic signed [FW-1:0] freq_b,
  input wire logic signed [FW-1:0] target_frequency,
  input wire logic signed [FW-1:0] digital_ref_a
);
  // --------------------------
  // shadow settings
  // --------------------------
  logic [7:0]           comb_ff;
  logic [15:0]          off_ff;
  logic [1:0]           quiet_ff;
  logic signed [FW+1:0] a_x, b_x, o_x, a_m, b_m, sum_x;
  logic                 settled;

  // outputs trail a write by two edges
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      comb_ff  <= RST_COMBINE;
      off_ff   <= RST_OFFSET;
      quiet_ff <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == OFS_COMBINE_SELECT) comb_ff <= reg_wdata[7:0];
      if (reg_wr && reg_addr == OFS_COMBINE_OFFSET) off_ff <= reg_wdata[15:0];
      quiet_ff <= reg_wr ? 2'h0 : (quiet_ff == 2'h3 ? 2'h3 : quiet_ff + 2'h1);
    end
  end

  // widened so sums cannot wrap
  always_comb begin
    a_x = freq_a;
    b_x = freq_b;
    o_x = $signed({1'b0, off_ff});
    a_m = a_x < 0 ? -a_x : a_x;
    b_m = b_x < 0 ? -b_x : b_x;
    sum_x = a_x + b_x + o_x;
    settled = quiet_ff >= 2'h2;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // --------------------------
  // assertions
  // --------------------------
  AST_UNIT_A: assert property (settled && comb_ff[3:0] == UNIT_A |-> target_frequency == freq_a)
    else $error("target not A");
  AST_SWITCH_A: assert property (settled && comb_ff[3:0] == UNIT_A_OR_B && !$past(source_switch)
    |-> target_frequency == freq_a) else $error("not A, switch off");
  AST_SWITCH_B: assert property (settled && comb_ff[3:0] == UNIT_A_OR_B && $past(source_switch)
    |-> target_frequency == freq_b) else $error("not B, switch on");
  AST_UNIT3_ARITH: assert property (settled && comb_ff == 8'h03 && $past(source_switch)
    |-> target_frequency == sum_x) else $error("switched sum wrong");
  AST_UNIT4_B: assert property (settled && comb_ff[3:0] == UNIT_B_OR_ARITH && !$past(source_switch)
    |-> target_frequency == freq_b) else $error("not B, switch off");
  AST_SUM: assert property (settled && comb_ff == 8'h01 |-> target_frequency == sum_x)
    else $error("sum wrong");
  AST_DIFF: assert property (settled && comb_ff == 8'h11 |-> target_frequency == a_x - b_x + o_x)
    else $error("difference wrong");
  AST_MAX: assert property (settled && comb_ff == 8'h21
    |-> target_frequency == ((a_m >= b_m) ? a_x : b_x) + o_x) else $error("max wrong");
  AST_MIN: assert property (settled && comb_ff == 8'h31
    |-> target_frequency == ((a_m <= b_m) ? a_x : b_x) + o_x) else $error("min wrong");
  AST_PRESET: assert property (!$past(rst_b) |-> digital_ref_a == $signed({8'h00, RST_PRESET}))
    else $error("ref A not preset");

  COV_SWITCH_B: cover property (settled && comb_ff[3:0] == UNIT_A_OR_B && source_switch);
  COV_MAX: cover property (settled && comb_ff == 8'h21);
  COV_MIN: cover property (settled && comb_ff == 8'h31);
endmodule // freq_ref_combiner_chk

bind frequency_reference_combiner freq_ref_combiner_chk #(.FW(FW)) i_chk (
  .core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .source_switch,
  .freq_a, .freq_b, .target_frequency, .digital_ref_a
);

`default_nettype wire

// [tb/freq_src_model.sv]
// model of the reference sources and switch terminal
`timescale 1ns/1ns
`default_nettype none

module freq_src_model (
  // bench control
  input  wire logic               core_clk,
  input  wire logic               set_en,
  input  wire logic [2:0]         set_idx,
  input  wire logic signed [15:0] set_val,
  input  wire logic               sw_req,
  // levels in 0.01 % of maximum frequency
  output logic signed [15:0]      analog_input_one,
  output logic signed [15:0]      pulse_input,
  output logic signed [15:0]      multi_ref_input,
  output logic signed [15:0]      simple_plc_input,
  output logic signed [15:0]      pid_input,
  output logic signed [15:0]      comm_input,
  output logic signed [15:0]      keypad_pot_input,
  // terminal function 14, high while active
  output logic                    source_switch
);
  // --------------------------
  // sampled levels
  // --------------------------
  logic signed [15:0] lvl [7] = '{default: 16'sh0};

  // levels move only on an edge
  always @(posedge core_clk) begin
    if (set_en && set_idx < 3'h7) lvl[set_idx] <= set_val;
    source_switch <= sw_req;
  end
  assign {analog_input_one, pulse_input, multi_ref_input} = {lvl[0], lvl[1], lvl[2]};
  assign {simple_plc_input, pid_input, comm_input} = {lvl[3], lvl[4], lvl[5]};
  assign keypad_pot_input = lvl[6];
endmodule // freq_src_model

`default_nettype wire

// [tb/frequency_reference_combiner_tb.sv]
// self-checking testbench for the frequency reference combiner
`timescale 1ns/1ns
`default_nettype none

module frequency_reference_combiner_tb;
  import freq_ref_pkg::*;

  // --------------------------
  // signals
  // --------------------------
  logic               core_clk = 1'b0;
  logic               rst_b = 1'b0;
  logic [7:0]         reg_addr = 8'h00;
  logic [31:0]        reg_wdata = 32'h0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [31:0]        reg_rdata;
  logic signed [15:0] analog_input_one, pulse_input, multi_ref_input, simple_plc_input;
  logic signed [15:0] pid_input, comm_input, keypad_pot_input;
  logic               source_switch, set_en = 1'b0, sw_req = 1'b0;
  logic               up_pulse = 1'b0, down_pulse = 1'b0, power_up_load = 1'b0;
  logic [2:0]         set_idx = 3'h0;
  logic signed [15:0] set_val = 16'sh0;
  logic signed [23:0] retained_a = 24'sh4d2, retained_b = 24'sh309;
  logic signed [23:0] freq_a, freq_b, target_frequency, digital_ref_a, digital_ref_b;
  int                 mismatches = 0;
  int                 check_count = 0;
  // levels: analog, pulse, multi, plc, pid, comm, keypad
  int         lv_init [7] = '{5000, 1000, 2000, 3000, 4000, 6000, 7000};
  logic [3:0] codes [5] = '{SRC_PULSE, SRC_SIMPLE_PLC, SRC_PID, SRC_COMM, SRC_KEYPAD_POT};
  logic [7:0] rst_ofs [8] = '{OFS_MAIN_GAIN, OFS_AUX_RANGE_PERCENT, OFS_PRESET_FREQUENCY,
    OFS_MAXIMUM_FREQUENCY, OFS_COMBINE_SELECT, OFS_COMBINE_OFFSET, OFS_AUX_RANGE_BASIS, 8'h40};
  int         rst_val [8] = '{1000, 100, 5000, 5000, 0, 0, 0, 0};

  always #5 core_clk = ~core_clk;

  frequency_reference_combiner #(.FW(24)) i_dut (
    .core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .analog_input_one, .pulse_input, .multi_ref_input, .simple_plc_input,
    .pid_input, .comm_input, .keypad_pot_input, .source_switch, .up_pulse,
    .down_pulse, .power_up_load, .retained_a, .retained_b, .freq_a, .freq_b,
    .target_frequency, .digital_ref_a, .digital_ref_b
  );
  freq_src_model i_src (
    .core_clk, .set_en, .set_idx, .set_val, .sw_req, .analog_input_one, .pulse_input,
    .multi_ref_input, .simple_plc_input, .pid_input, .comm_input, .keypad_pot_input,
    .source_switch
  );

  // --------------------------
  // access and compare tasks
  // --------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %0d seen %0d", nm, $signed(e), $signed(g));
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic set_src(input logic [2:0] i, input logic signed [15:0] v);
    @(posedge core_clk);
    set_en <= 1'b1;
    set_idx <= i;
    set_val <= v;
    @(posedge core_clk);
    set_en <= 1'b0;
  endtask
  task automatic pulse(input logic [2:0] w);
    @(posedge core_clk);
    {power_up_load, up_pulse, down_pulse} <= w;
    @(posedge core_clk);
    {power_up_load, up_pulse, down_pulse} <= 3'h0;
  endtask
  // settings and sources both take two edges
  task automatic chk_tgt(input int e);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk("target_frequency", e, target_frequency);
  endtask
  // expected target, A 150 Hz, offset 1 Hz
  function automatic int exp_tgt(int u, int t, int s, int b);
    int a = 15000;
    int m = b < 0 ? -b : b;
    int ar = 100 + (t == 0 ? a + b : t == 1 ? a - b :
      t == 2 ? (a >= m ? a : b) : (a <= m ? a : b));
    case (u)
      0: return a;
      1: return ar;
      2: return s ? b : a;
      3: return s ? ar : a;
      default: return s ? ar : b;
    endcase
  endfunction
  task automatic tally_and_finish;
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // --------------------------
  // tests
  // --------------------------
  initial begin
    int u, t, s, bv;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    chk("digital_ref_a", 5000, digital_ref_a);
    chk_tgt(5000);
    foreach (rst_ofs[i]) rd(rst_ofs[i], rst_val[i]);
    foreach (lv_init[i]) set_src(3'(i), 16'(lv_init[i]));
    // maxf 200 Hz, gain 1.5, A analog, B multi, offset 1 Hz
    wr(OFS_MAXIMUM_FREQUENCY, 32'h4e20);
    wr(OFS_MAIN_GAIN, 32'h5dc);
    wr(OFS_MAIN_SOURCE_SELECT, 32'h2);
    wr(OFS_AUX_SOURCE_SELECT, 32'h6);
    wr(OFS_AUX_RANGE_BASIS, 32'h1);
    wr(OFS_COMBINE_OFFSET, 32'h64);
    chk_tgt(15000);
    // all units, tens and switch cases, |B| above and below A
    for (int n = 0; n < 80; n++) begin
      s = n % 2;
      u = (n / 2) % 5;
      t = (n / 10) % 4;
      bv = n < 40 ? -16000 : 4000;
      if (n % 40 == 0) set_src(3'h2, 16'(bv / 2));
      wr(OFS_COMBINE_SELECT, {24'h0, 4'(t), 4'(u)});
      @(posedge core_clk) sw_req <= s[0];
      chk_tgt(exp_tgt(u, t, s, bv));
    end
    rd(OFS_STATUS_TARGET, 4100);
    wr(OFS_COMBINE_SELECT, 32'h01);
    wr(OFS_AUX_RANGE_BASIS, 32'h2);
    chk_tgt(18100);
    wr(OFS_MAIN_GAIN, 32'h3e8);
    chk_tgt(12100);
    wr(OFS_MAIN_GAIN, 32'h5dc);
    wr(OFS_AUX_RANGE_BASIS, 32'h1);
    wr(OFS_AUX_RANGE_PERCENT, 32'h32);
    chk_tgt(17100);
    wr(OFS_COMBINE_SELECT, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_MAIN_SOURCE_SELECT, {28'h0, codes[i]});
      chk_tgt(3 * lv_init[i ? i + 2 : 1]);
    end
    wr(OFS_MAIN_SOURCE_SELECT, 32'h2);
    wr(OFS_COMBINE_SELECT, 32'h04);
    @(posedge core_clk) sw_req <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      wr(OFS_AUX_SOURCE_SELECT, {28'h0, codes[i]}); // kept apart from main
      chk_tgt(lv_init[i ? i + 2 : 1]);
    end
    // digital sources
    wr(OFS_AUX_SOURCE_SELECT, 32'h6);
    wr(OFS_COMBINE_SELECT, 32'h0);
    wr(OFS_PRESET_FREQUENCY, 32'hbb8);
    wr(OFS_MAIN_SOURCE_SELECT, 32'h0);
    pulse(3'h4);
    chk_tgt(4500);
    wr(OFS_MAIN_SOURCE_SELECT, 32'h1);
    wr(OFS_AUX_SOURCE_SELECT, 32'h0);
    wr(OFS_COMBINE_SELECT, 32'h01);
    pulse(3'h4);
    chk_tgt(1951);
    chk("digital_ref_b", 0, digital_ref_b);
    pulse(3'h2);
    chk_tgt(1953);
    chk("digital_ref_b", 1, digital_ref_b);
    pulse(3'h1);
    chk_tgt(1951);
    tally_and_finish();
  end

  // hang guard, about twenty-five times the test length
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    tally_and_finish();
  end
endmodule // frequency_reference_combiner_tb

`default_nettype wire
